// >>> verilog/socket_status_change_event_mask.sv
`timescale 1ns/10ps
// Behaviour
// - 32-bit socket registers in memory space
// - Each socket decoded by its own base
// - Power-management register at offset 20h
// - Flags record change only, not value
// - Writing one clears a flag
// - Inject register write of one sets flag
// - Bus reset clears all flags
// - Flags may reset again after card reset
// - Pending flag interrupts when enabled
// - Bit 3 set on power-cycle change
// - Bit 2 set on detect-two change
// - Bit 1 set on detect-one change
// - CardBus card: bit 0 on rising edge
// - 16-bit card: bit 0 on both edges
// - Event registers: bits 31..4 read as zero
// - Enables gate interrupt only, not flags
// - Enable bit 3 gates power-cycle event
// - Enable field 2..1 at 11 gates detect
// - Enable bit 0 gates card status
module socket_status_change_event_mask
    import socket_evt_pkg::*;
(
    // Clock and reset
    input  wire logic         i_sys_clk,
    input  wire logic         i_reset,
    // Register port, already decoded by this socket's base
    input  wire reg_req_t     i_req,
    output logic [31:0]       o_rdata,
    // Card socket pins
    input  wire socket_pins_t i_pins,
    input  wire logic         i_card_is_cardbus,
    // Status change interrupt request
    output logic              o_status_change_interrupt
);

    socket_pins_t pins_s;
    socket_pins_t pins_prev_q;
    logic         cardbus_meta_q;
    logic         cardbus_q;
    logic         seen_q;
    logic [3:0]   change_flags_q;
    logic [3:0]   change_flags_d;
    logic [3:0]   change_enables_q;
    logic [3:0]   inject_live_q;
    logic [31:0]  control_word_q;
    logic [31:0]  power_mgmt_q;
    logic [3:0]   hw_set;
    logic [3:0]   irq_gate;
    logic [31:0]  rdata_d;
    logic         irq_d;
    logic         wr_flags;
    logic         wr_enables;
    logic         wr_inject;
    logic         card_status_state;

    // Address match for a write strobe
    function automatic logic hit(input reg_req_t r, input logic [7:0] off);
        hit = r.sel && r.wr && (r.addr == off);
    endfunction

    // Socket pins cross into the bus clock domain
    socket_pin_sync u_sync (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_pins    (i_pins),
        .o_pins    (pins_s)
    );

    // Card type strap is a level from the socket side
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            cardbus_meta_q <= 1'b0;
            cardbus_q      <= 1'b0;
        end else begin
            cardbus_meta_q <= i_card_is_cardbus;
            cardbus_q      <= cardbus_meta_q;
        end
    end

    // Previous sample, loaded once before edges are trusted
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            pins_prev_q <= '0;
            seen_q      <= 1'b0;
        end else begin
            pins_prev_q <= pins_s;
            seen_q      <= 1'b1;
        end
    end

    assign wr_flags   = hit(i_req, OFF_CHANGE_FLAGS);
    assign wr_enables = hit(i_req, OFF_CHANGE_ENABLES);
    assign wr_inject  = hit(i_req, OFF_EVENT_INJECT);

    // Card status line as seen in the live view
    assign card_status_state = pins_s.status_change | inject_live_q[BIT_CARD_STATUS];

    // Hardware change detection; only the fact of a change is kept
    always_comb begin
        hw_set = '0;
        if (seen_q) begin
            hw_set[BIT_POWER_CYCLE] = pins_s.power_cycle ^ pins_prev_q.power_cycle;
            hw_set[BIT_DETECT_TWO]  = pins_s.detect_two ^ pins_prev_q.detect_two;
            hw_set[BIT_DETECT_ONE]  = pins_s.detect_one ^ pins_prev_q.detect_one;
            if (cardbus_q) begin
                hw_set[BIT_CARD_STATUS] = pins_s.status_change
                                        & ~pins_prev_q.status_change;
            end else begin
                hw_set[BIT_CARD_STATUS] = pins_s.status_change
                                        ^ pins_prev_q.status_change;
            end
        end
    end

    // Set beats clear so a change in the clearing cycle survives
    always_comb begin
        change_flags_d = change_flags_q;
        if (wr_flags) begin
            change_flags_d = change_flags_d & ~i_req.wdata[EVT_W-1:0];
        end
        if (wr_inject) begin
            change_flags_d = change_flags_d | i_req.wdata[EVT_W-1:0];
        end
        change_flags_d = change_flags_d | hw_set;
    end

    // Flags run whatever the enables say
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            change_flags_q <= FLAGS_RESET;
        end else begin
            change_flags_q <= change_flags_d;
        end
    end

    // Last injected values kept for the live-status view
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            inject_live_q <= '0;
        end else if (wr_inject) begin
            inject_live_q <= i_req.wdata[EVT_W-1:0];
        end
    end

    // Enables, control and power-management words
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            change_enables_q <= ENABLES_RESET;
            control_word_q   <= CONTROL_RESET;
            power_mgmt_q     <= PM_RESET;
        end else begin
            if (wr_enables) begin
                change_enables_q <= i_req.wdata[EVT_W-1:0];
            end
            if (hit(i_req, OFF_CONTROL_WORD)) begin
                control_word_q <= i_req.wdata;
            end
            if (hit(i_req, OFF_POWER_MGMT)) begin
                power_mgmt_q <= i_req.wdata;
            end
        end
    end

    // Detect pair only counts when both enable bits are set
    always_comb begin
        irq_gate = '0;
        irq_gate[BIT_POWER_CYCLE] = change_enables_q[BIT_POWER_CYCLE];
        irq_gate[BIT_CARD_STATUS] = change_enables_q[BIT_CARD_STATUS];
        irq_gate[BIT_DETECT_ONE]  = change_enables_q[BIT_DETECT_ONE]
                                  & change_enables_q[BIT_DETECT_TWO];
        irq_gate[BIT_DETECT_TWO]  = irq_gate[BIT_DETECT_ONE];
    end

    // Level request from the next flag state; stale flags fire on enable
    assign irq_d = |(change_flags_d & irq_gate);

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_status_change_interrupt <= 1'b0;
        end else begin
            o_status_change_interrupt <= irq_d;
        end
    end

    // Read mux; unmapped offsets and reserved bits read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (i_req.sel && !i_req.wr) begin
            case (i_req.addr)
                OFF_CHANGE_FLAGS: begin
                    rdata_d[EVT_W-1:0] = change_flags_q;
                end
                OFF_CHANGE_ENABLES: begin
                    rdata_d[EVT_W-1:0] = change_enables_q;
                end
                OFF_LIVE_STATUS: begin
                    rdata_d[BIT_CARD_STATUS] = card_status_state;
                    rdata_d[BIT_DETECT_ONE]  = pins_s.detect_one;
                    rdata_d[BIT_DETECT_TWO]  = pins_s.detect_two;
                    rdata_d[BIT_POWER_CYCLE] = pins_s.power_cycle;
                end
                OFF_CONTROL_WORD: begin
                    rdata_d = control_word_q;
                end
                OFF_POWER_MGMT: begin
                    rdata_d = power_mgmt_q;
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    // Registered read data, one cycle after the request
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_rdata <= 32'h0000_0000;
        end else begin
            o_rdata <= rdata_d;
        end
    end

endmodule

// >>> pkg/socket_evt_pkg.sv
package socket_evt_pkg;

    // Register offsets within one socket's register set
    localparam logic [7:0] OFF_CHANGE_FLAGS   = 8'h00;
    localparam logic [7:0] OFF_CHANGE_ENABLES = 8'h04;
    localparam logic [7:0] OFF_LIVE_STATUS    = 8'h08;
    localparam logic [7:0] OFF_EVENT_INJECT   = 8'h0C;
    localparam logic [7:0] OFF_CONTROL_WORD   = 8'h10;
    localparam logic [7:0] OFF_POWER_MGMT     = 8'h20;

    // Field positions shared by flags, enables and live status
    localparam int BIT_CARD_STATUS = 0;
    localparam int BIT_DETECT_ONE  = 1;
    localparam int BIT_DETECT_TWO  = 2;
    localparam int BIT_POWER_CYCLE = 3;
    localparam int EVT_W           = 4;

    // Reset values
    localparam logic [3:0]  FLAGS_RESET   = 4'h0;
    localparam logic [3:0]  ENABLES_RESET = 4'h0;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] PM_RESET      = 32'h0000_0000;

    // Host register request, one word per access
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } reg_req_t;

    // Sampled card socket inputs
    typedef struct packed {
        logic power_cycle;
        logic detect_two;
        logic detect_one;
        logic status_change;
    } socket_pins_t;

endpackage

// >>> verilog/socket_pin_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for the socket inputs
module socket_pin_sync
    import socket_evt_pkg::*;
(
    // Clock and reset
    input  wire logic         i_sys_clk,
    input  wire logic         i_reset,
    // Raw and synchronised pins
    input  wire socket_pins_t i_pins,
    output socket_pins_t      o_pins
);

    socket_pins_t meta_q;
    socket_pins_t sync_q;

    // First stage is read only by the second
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_pins;
            sync_q <= meta_q;
        end
    end

    assign o_pins = sync_q;

endmodule

// >>> verif/card_socket_model.sv
`timescale 1ns/10ps
// Card socket side: pins step to the commanded levels
module card_socket_model
    import socket_evt_pkg::*;
(
    // Clock and commanded levels
    input  wire logic       i_sys_clk,
    input  wire logic [3:0] i_level,
    // Socket pins
    output socket_pins_t    o_pins
);
    initial o_pins = '0;
    // Step at the falling edge so no pin moves near the sampling edge
    always @(negedge i_sys_clk) begin
        o_pins <= socket_pins_t'(i_level);
    end
endmodule

// >>> verif/socket_status_change_event_mask_asserts.sv
`timescale 1ns/10ps
// Port checks of the status change event logic
module socket_status_change_event_mask_asserts
    import socket_evt_pkg::*;
(
    input wire logic         i_sys_clk,
    input wire logic         i_reset,
    input wire reg_req_t     i_req,
    input wire logic [31:0]  o_rdata,
    input wire socket_pins_t i_pins,
    input wire logic         i_card_is_cardbus,
    input wire logic         o_status_change_interrupt
);
    logic       rd;
    logic       wr;
    logic [3:0] en_q;
    logic [3:0] gate;
    // Enable shadow; the detect pair only counts at 11
    always_ff @(posedge i_sys_clk) begin
        if (i_reset)
            en_q <= ENABLES_RESET;
        else if (wr && i_req.addr == OFF_CHANGE_ENABLES)
            en_q <= i_req.wdata[3:0];
    end
    assign rd   = i_req.sel && !i_req.wr;
    assign wr   = i_req.sel && i_req.wr;
    assign gate = {en_q[3], {2{en_q[2] & en_q[1]}}, en_q[0]};
    default clocking dc @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    sequence pm_write; wr && i_req.addr == OFF_POWER_MGMT; endsequence
    sequence pm_read; rd && i_req.addr == OFF_POWER_MGMT; endsequence
    sequence pm_quiet; !(wr && i_req.addr == OFF_POWER_MGMT); endsequence
    a_reset_clears_out: assert property (
        $fell(i_reset) |-> o_rdata == 32'h0 && !o_status_change_interrupt)
        else $error("outputs not cleared by reset");
    a_idle_rdata_zero: assert property (!rd |=> o_rdata == 32'h0)
        else $error("read data outside a read");
    a_unmapped_zero: assert property (
        rd && (i_req.addr == OFF_EVENT_INJECT || i_req.addr == 8'h14) |=> o_rdata == 32'h0)
        else $error("write-only or unmapped place read nonzero");
    a_pm_store_rw: assert property (
        pm_write ##1 pm_quiet ##1 pm_read |=> o_rdata == $past(i_req.wdata, 3))
        else $error("power management store lost data");
    a_gate_blocks_irq: assert property (
        gate == 4'h0 && !(wr && i_req.addr == OFF_CHANGE_ENABLES) |=> !o_status_change_interrupt)
        else $error("interrupt with all events disabled");
    a_inject_raises_irq: assert property (
        wr && i_req.addr == OFF_EVENT_INJECT && (i_req.wdata[3:0] & gate) != 4'h0
        |=> o_status_change_interrupt)
        else $error("enabled injected event gave no interrupt");
    a_pin_change_irq: assert property (
        gate == 4'hF && $changed(i_pins[3:1]) |-> ##[1:5] o_status_change_interrupt)
        else $error("pin change gave no interrupt");
    a_irq_has_flag: assert property (
        rd && i_req.addr == OFF_CHANGE_FLAGS && o_status_change_interrupt
        |=> o_rdata[3:0] != 4'h0)
        else $error("interrupt with no flag set");
endmodule
bind socket_status_change_event_mask socket_status_change_event_mask_asserts u_asserts (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_req(i_req), .o_rdata(o_rdata),
    .i_pins(i_pins), .i_card_is_cardbus(i_card_is_cardbus),
    .o_status_change_interrupt(o_status_change_interrupt));

// >>> verif/socket_status_change_event_mask_tb_top.sv
`timescale 1ns/10ps
module socket_status_change_event_mask_tb_top
    import socket_evt_pkg::*;
;
    logic         i_sys_clk = 1'b0;
    logic         i_reset   = 1'b1;
    reg_req_t     req       = '0;
    logic         cardbus   = 1'b1;
    logic [3:0]   level     = 4'h0;
    logic [31:0]  lfsr      = 32'h523BF694;
    logic [31:0]  rdata;
    logic         irq;
    logic         taken     = 1'b0;
    socket_pins_t pins;
    logic [31:0]  expq[$];
    int           num_errors   = 0;
    int           total_checks = 0;
    int           cycles       = 0;

    always #50 i_sys_clk = ~i_sys_clk;
    socket_status_change_event_mask u_socket_status_change_event_mask (
        .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_req(req), .o_rdata(rdata),
        .i_pins(pins), .i_card_is_cardbus(cardbus), .o_status_change_interrupt(irq));
    card_socket_model u_card_socket_model (.i_sys_clk(i_sys_clk), .i_level(level), .o_pins(pins));

    // Next random word from the bench's shift register
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask
    // One access; a read notes its expected word for the monitor
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(negedge i_sys_clk);
        req <= '{1'b1, w, a, d};
        if (!w)
            expq.push_back(d);
        @(negedge i_sys_clk);
        req <= '0;
    endtask
    // Read data stands one cycle, so compare it in that cycle
    always @(posedge i_sys_clk) taken <= req.sel && !req.wr;
    always @(negedge i_sys_clk) if (taken) check(rdata, expq.pop_front());
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            give_verdict();
        end
    end

    initial begin
        repeat (6) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_reset <= 1'b0;
        acc(0, OFF_CHANGE_FLAGS, 32'h0);
        acc(0, OFF_CHANGE_ENABLES, 32'h0);
        acc(0, OFF_EVENT_INJECT, 32'h0);
        acc(0, 8'h14, 32'h0);
        for (int i = 0; i < 2; i++) begin
            lfsr = lfsr_next(lfsr);
            acc(1, i ? OFF_POWER_MGMT : OFF_CONTROL_WORD, lfsr);
            acc(0, i ? OFF_POWER_MGMT : OFF_CONTROL_WORD, lfsr);
        end
        $display("register test done");
        // Inject, zeros leave the flag, a one clears it
        for (int k = 0; k < 4; k++) begin
            acc(1, OFF_EVENT_INJECT, 32'h1 << k);
            acc(1, OFF_CHANGE_FLAGS, ~(32'h1 << k));
            acc(0, OFF_CHANGE_FLAGS, 32'h1 << k);
            acc(1, OFF_CHANGE_FLAGS, 32'h1 << k);
            acc(0, OFF_CHANGE_FLAGS, 32'h0);
        end
        $display("inject test done");
        // Enable codes 8, 6, 4, 2, 1 and 0 against all flags set; 01 and 10 stay off
        acc(1, OFF_EVENT_INJECT, 32'hF);
        acc(0, OFF_CHANGE_FLAGS, 32'hF);
        for (int i = 0; i < 6; i++) begin
            acc(1, OFF_CHANGE_ENABLES, (32'h0001_2468 >> (4 * i)) & 32'hF);
            idle(1);
            check({31'h0, irq}, (32'h13 >> i) & 32'h1);
        end
        acc(1, OFF_EVENT_INJECT, 32'h0);
        acc(1, OFF_CHANGE_ENABLES, 32'hFFFFFFFF);
        acc(0, OFF_CHANGE_ENABLES, 32'hF);
        acc(1, OFF_CHANGE_FLAGS, 32'hF);
        idle(1);
        check({31'h0, irq}, 32'h0);
        $display("enable test done");
        // Pin steps in both card modes; a falling edge in CardBus mode is ignored
        for (int i = 0; i < 8; i++) begin
            cardbus <= 8'hFC >> i;
            idle(3);
            level <= 32'h0E620101 >> (4 * i);
            idle(8);
            check({31'h0, irq}, {31'h0, |((32'hE8420111 >> (4 * i)) & 32'hF)});
            acc(0, OFF_LIVE_STATUS, {28'h0, level});
            acc(0, OFF_CHANGE_FLAGS, (32'hE8420111 >> (4 * i)) & 32'hF);
            acc(1, OFF_CHANGE_FLAGS, 32'hF);
        end
        $display("pin test done");
        // Second reset with flags and enables set
        acc(1, OFF_EVENT_INJECT, 32'hE);
        i_reset <= 1'b1;
        idle(2);
        i_reset <= 1'b0;
        acc(0, OFF_CHANGE_FLAGS, 32'h0);
        acc(0, OFF_CHANGE_ENABLES, 32'h0);
        check({31'h0, irq}, 32'h0);
        idle(2);
        $display("reset test done");
        give_verdict();
    end
endmodule
